// ==== tlb_limit_bank.sv ====
// Temperature and input overvoltage limit bank with fault response engines.
// Assumes measurements, command strobes and enables come from logic on core_clk_in.
// Overview of operation
// R1 - Over-temperature warning sets summary, flag, alert
// R2 - Over-temp warning resets 110C, range 0..175C
// R3 - Under-temperature warning sets summary, flag, alert
// R4 - Under-temp warning resets -50C, range -55..25C
// R5 - Under-temp fault clears above warning threshold
// R6 - Under-temp fault threshold resets -55C, word
// R7 - Under-temp action byte resets to 80h
// R8 - Behaviour 00 ignores the fault
// R9 - Behaviour 01 delays, disables, then retries
// R10 - Behaviour 10 disables at once, then retries
// R11 - Behaviour 11 disabled only while fault present
// R12 - Fault bits sticky until clear-faults command
// R13 - Retry 000 stays off until restart
// R14 - Retry 1..6 restarts that many times
// R15 - Retry 111 restarts continuously without checking
// R16 - Time count sets delay and retry spacing
// R17 - Input overvoltage threshold resets 14.5V, 0..16V
// R18 - Input overvoltage action byte resets 80h
// R19 - Delay time spaces successive restart attempts
// R20 - Thresholds exchanged as linear two-byte words
// R21 - Signed exponent 15:11, signed mantissa 10:0
`timescale 1ns/1ps
`include "tlb_defs.svh"

module tlb_fault_resp #(
  parameter int UNIT_CYCLES = `TLB_CYC(`TLB_UT_UNIT_US)
) (
  input  wire logic                    core_clk_in, // Core clock.
  input  wire logic                    nrst_in,     // Synchronous reset, low.
  input  wire logic                    run_en_in,   // Rail enabled; low restarts.
  input  wire logic                    fault_in,    // Fault present level.
  input  wire tlb_pkg::tlb_action_type action_in,   // Response byte.
  output logic                         out_en_out   // Output permitted.
);
  tlb_pkg::tlb_resp_reg_type r;
  tlb_pkg::tlb_resp_reg_type next_r;
  logic [31:0]               dly;

  if (UNIT_CYCLES < 1) begin : g_chk
    $error("UNIT_CYCLES must be at least one");
  end

  assign dly = 32'(action_in.tim) * 32'(UNIT_CYCLES); // [R16] [R19]
  assign out_en_out = r.en;

  always_comb begin
    next_r = r;
    if (r.cnt != 32'h0) begin
      next_r.cnt = r.cnt - 32'h1;
    end
    unique case (r.state)
      tlb_pkg::st_idle: begin
        if (fault_in) begin
          unique case (action_in.beh)
            `TLB_BEH_IGN: next_r.en = 1'b1; // [R8]
            `TLB_BEH_DLY: begin // [R9]
              next_r.state = tlb_pkg::st_delay;
              next_r.cnt   = dly;
            end
            `TLB_BEH_OFF: begin // [R10]
              next_r.en    = 1'b0;
              next_r.state = tlb_pkg::st_off;
            end
            `TLB_BEH_HLD: begin // [R11]
              next_r.en    = 1'b0;
              next_r.held  = 1'b1;
              next_r.state = tlb_pkg::st_latch;
            end
          endcase
        end
      end
      tlb_pkg::st_delay: begin
        if (!fault_in) begin
          next_r.state = tlb_pkg::st_idle;
        end else if (r.cnt == 32'h0) begin // [R9]
          next_r.en    = 1'b0;
          next_r.state = tlb_pkg::st_off;
        end
      end
      tlb_pkg::st_off: begin
        if (action_in.retry == `TLB_RTY_NONE) begin // [R13]
          next_r.state = tlb_pkg::st_latch;
        end else if (action_in.retry == `TLB_RTY_CONT ||
                     r.tries < action_in.retry) begin // [R14] [R15]
          next_r.state = tlb_pkg::st_wait;
          next_r.cnt   = dly; // [R19]
        end else begin
          next_r.state = tlb_pkg::st_latch;
        end
      end
      tlb_pkg::st_wait: begin
        // Continuous retry restarts blindly; idle then re-detects the fault.
        if (r.cnt == 32'h0) begin
          next_r.en    = 1'b1;
          next_r.state = tlb_pkg::st_idle;
          if (action_in.retry != `TLB_RTY_CONT) begin // [R15]
            next_r.tries = r.tries + 3'h1; // [R14]
          end
        end
      end
      tlb_pkg::st_latch: begin
        if (r.held && !fault_in) begin // [R11]
          next_r.en    = 1'b1;
          next_r.held  = 1'b0;
          next_r.state = tlb_pkg::st_idle;
        end
      end
      default: next_r.state = tlb_pkg::st_idle;
    endcase
    // Disabling the rail is the restart that ends a latched shutdown.
    if (!run_en_in) begin // [R13]
      next_r       = '0;
      next_r.state = tlb_pkg::st_idle;
      next_r.en    = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      r       <= '0;
      r.state <= tlb_pkg::st_idle;
      r.en    <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  property p_ignore;
    @(posedge core_clk_in) disable iff (!nrst_in)
      r.state == tlb_pkg::st_idle && action_in.beh == `TLB_BEH_IGN && run_en_in
      |=> out_en_out;
  endproperty
  a_ignore: assert property (p_ignore) else $error("ignored fault disabled output"); // [R8]

  property p_off_now;
    @(posedge core_clk_in) disable iff (!nrst_in)
      r.state == tlb_pkg::st_idle && fault_in && run_en_in &&
      action_in.beh == `TLB_BEH_OFF |=> !out_en_out;
  endproperty
  a_off_now: assert property (p_off_now) else $error("output not disabled at once"); // [R10]

  property p_hold_rel;
    @(posedge core_clk_in) disable iff (!nrst_in)
      r.state == tlb_pkg::st_latch && r.held && !fault_in && run_en_in
      |=> out_en_out && r.state == tlb_pkg::st_idle;
  endproperty
  a_hold_rel: assert property (p_hold_rel) else $error("output not re-enabled"); // [R11]

  property p_no_retry;
    @(posedge core_clk_in) disable iff (!nrst_in)
      r.state == tlb_pkg::st_latch && !r.held && run_en_in
      |=> !out_en_out ##1 (!out_en_out || !$past(run_en_in));
  endproperty
  a_no_retry: assert property (p_no_retry) else $error("latched output restarted"); // [R13]

  property p_delay;
    @(posedge core_clk_in) disable iff (!nrst_in)
      r.state == tlb_pkg::st_delay && r.cnt != 32'h0 && run_en_in |=> out_en_out;
  endproperty
  a_delay: assert property (p_delay) else $error("output cut before delay"); // [R9]
endmodule : tlb_fault_resp

module tlb_limit_bank #(
  parameter int UT_UNIT_CYCLES = `TLB_CYC(`TLB_UT_UNIT_US),
  parameter int VO_UNIT_CYCLES = `TLB_CYC(`TLB_VO_UNIT_US)
) (
  input  wire logic                   core_clk_in,       // Core clock, 200 MHz.
  input  wire logic                   nrst_in,           // Synchronous reset, low.
  input  wire logic [15:0]            temp_l11_in,       // Measured temperature.
  input  wire logic [15:0]            vin_l11_in,        // Measured input voltage.
  input  wire logic                   run_en_in,         // Rail enable.
  input  wire logic                   clear_faults_in,   // Clear-faults command pulse.
  input  wire logic                   reg_wr_in,         // Command write strobe.
  input  wire logic                   reg_rd_in,         // Command read strobe.
  input  wire logic [7:0]             reg_cmd_in,        // Command code.
  input  wire logic [15:0]            reg_wdata_in,      // Write word or byte.
  output logic [15:0]                 reg_rdata_out,     // Read word or byte.
  output logic                        reg_ack_out,       // Access done pulse.
  output logic                        reg_nak_out,       // Access refused pulse.
  output tlb_pkg::tlb_status_type     status_out,        // Sticky fault flags.
  output logic                        temp_summary_out,  // Temperature summary.
  output logic                        host_alert_out,    // Host notification.
  output logic                        output_en_out      // Rail may run.
);
  tlb_pkg::tlb_bank_reg_type r;
  tlb_pkg::tlb_bank_reg_type next_r;
  logic signed [47:0]        tf;
  logic signed [47:0]        vf;
  logic signed [47:0]        wf;
  logic                      ot_hi;
  logic                      ut_lo;
  logic                      uf_lo;
  logic                      ut_up;
  logic                      vo_hi;
  logic                      ut_en;
  logic                      vo_en;

  // Linear word to fixed point with TLB_FRAC fraction bits; exact for all codes.
  function automatic logic signed [47:0] to_fix(input logic [15:0] w); // [R21]
    logic signed [4:0]  e;
    logic signed [47:0] m;
    int                 sh;
    e  = w[`TLB_EXP_HI:`TLB_EXP_LO];
    m  = 48'(signed'(w[`TLB_MAN_HI:0]));
    sh = int'(e) + `TLB_FRAC;
    to_fix = m <<< sh;
  endfunction : to_fix

  function automatic logic in_rng(input logic signed [47:0] v,
                                  input int lo,
                                  input int hi);
    logic signed [47:0] l;
    logic signed [47:0] h;
    l = 48'(lo) <<< `TLB_FRAC;
    h = 48'(hi) <<< `TLB_FRAC;
    in_rng = (v >= l) && (v <= h);
  endfunction : in_rng

  assign tf    = to_fix(temp_l11_in);
  assign vf    = to_fix(vin_l11_in);
  assign wf    = to_fix(reg_wdata_in); // [R20]
  assign ot_hi = tf > to_fix(r.otw); // [R1]
  assign ut_lo = tf < to_fix(r.utw); // [R3]
  assign uf_lo = tf < to_fix(r.utf);
  assign ut_up = tf > to_fix(r.utw); // [R5]
  assign vo_hi = vf > to_fix(r.vof);

  tlb_fault_resp #(
    .UNIT_CYCLES (UT_UNIT_CYCLES)
  ) u_ut_resp (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .run_en_in   (run_en_in),
    .fault_in    (r.ut_present),
    .action_in   (r.uta),
    .out_en_out  (ut_en)
  );

  tlb_fault_resp #(
    .UNIT_CYCLES (VO_UNIT_CYCLES)
  ) u_vo_resp (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .run_en_in   (run_en_in),
    .fault_in    (vo_hi),
    .action_in   (r.voa),
    .out_en_out  (vo_en)
  );

  always_comb begin
    next_r     = r;
    next_r.ack = 1'b0;
    next_r.nak = 1'b0;
    // Hysteresis: declared at the fault limit, released above the warning limit.
    if (uf_lo) begin
      next_r.ut_present = 1'b1;
    end else if (ut_up) begin // [R5]
      next_r.ut_present = 1'b0;
    end
    // Clear first so that an event in the same cycle still sets its flag.
    if (clear_faults_in) begin // [R12]
      next_r.sts = '0;
    end
    if (ot_hi) next_r.sts.ot_warn = 1'b1; // [R1]
    if (ut_lo) next_r.sts.ut_warn = 1'b1; // [R3]
    if (r.ut_present) next_r.sts.ut_fault = 1'b1; // [R12]
    if (vo_hi) next_r.sts.vin_ov = 1'b1; // [R12]
    if (reg_wr_in) begin
      next_r.ack = 1'b1;
      case (reg_cmd_in)
        `TLB_CMD_OTW: begin
          if (in_rng(wf, `TLB_OT_MIN, `TLB_OT_MAX)) next_r.otw = reg_wdata_in; // [R2]
          else next_r.nak = 1'b1;
        end
        `TLB_CMD_UTW: begin
          if (in_rng(wf, `TLB_UT_MIN, `TLB_UT_MAX)) next_r.utw = reg_wdata_in; // [R4]
          else next_r.nak = 1'b1;
        end
        `TLB_CMD_UTF: begin
          if (in_rng(wf, `TLB_UT_MIN, `TLB_UT_MAX)) next_r.utf = reg_wdata_in; // [R6]
          else next_r.nak = 1'b1;
        end
        `TLB_CMD_VOF: begin
          if (in_rng(wf, `TLB_VO_MIN, `TLB_VO_MAX)) next_r.vof = reg_wdata_in; // [R17]
          else next_r.nak = 1'b1;
        end
        `TLB_CMD_UTA: next_r.uta = reg_wdata_in[7:0]; // [R7]
        `TLB_CMD_VOA: next_r.voa = reg_wdata_in[7:0]; // [R18]
        default:      next_r.nak = 1'b1;
      endcase
    end else if (reg_rd_in) begin
      next_r.ack = 1'b1;
      case (reg_cmd_in)
        `TLB_CMD_OTW: next_r.rdata = r.otw; // [R20]
        `TLB_CMD_UTW: next_r.rdata = r.utw;
        `TLB_CMD_UTF: next_r.rdata = r.utf;
        `TLB_CMD_VOF: next_r.rdata = r.vof;
        `TLB_CMD_UTA: next_r.rdata = {8'h00, r.uta};
        `TLB_CMD_VOA: next_r.rdata = {8'h00, r.voa};
        default: begin
          next_r.rdata = 16'h0000;
          next_r.nak   = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      r     <= '0;
      r.otw <= `TLB_RST_OTW; // [R2]
      r.utw <= `TLB_RST_UTW; // [R4]
      r.utf <= `TLB_RST_UTF; // [R6]
      r.uta <= `TLB_RST_ACT; // [R7]
      r.vof <= `TLB_RST_VOF; // [R17]
      r.voa <= `TLB_RST_ACT; // [R18]
    end else begin
      r <= next_r;
    end
  end

  assign reg_rdata_out    = r.rdata;
  assign reg_ack_out      = r.ack;
  assign reg_nak_out      = r.nak;
  assign status_out       = r.sts;
  assign temp_summary_out = r.sts.ot_warn | r.sts.ut_warn | r.sts.ut_fault; // [R1] [R3]
  assign host_alert_out   = |r.sts;
  assign output_en_out    = run_en_in & ut_en & vo_en;

  property p_ot_set;
    @(posedge core_clk_in) disable iff (!nrst_in)
      ot_hi |=> status_out.ot_warn && temp_summary_out && host_alert_out;
  endproperty
  a_ot_set: assert property (p_ot_set) else $error("warning not flagged"); // [R1]

  property p_ut_set;
    @(posedge core_clk_in) disable iff (!nrst_in)
      ut_lo |=> status_out.ut_warn && temp_summary_out;
  endproperty
  a_ut_set: assert property (p_ut_set) else $error("under warning not flagged"); // [R3]

  property p_sticky;
    @(posedge core_clk_in) disable iff (!nrst_in)
      status_out.vin_ov && !clear_faults_in |=> status_out.vin_ov;
  endproperty
  a_sticky: assert property (p_sticky) else $error("fault bit lost"); // [R12]

  property p_hyst;
    @(posedge core_clk_in) disable iff (!nrst_in)
      r.ut_present && !ut_up |=> r.ut_present;
  endproperty
  a_hyst: assert property (p_hyst) else $error("fault released early"); // [R5]

  property p_reset_vals;
    @(posedge core_clk_in)
      !nrst_in |=> r.otw == `TLB_RST_OTW && r.utw == `TLB_RST_UTW &&
                   r.utf == `TLB_RST_UTF && r.vof == `TLB_RST_VOF;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad threshold reset"); // [R2]

  property p_act_reset;
    @(posedge core_clk_in)
      !nrst_in |=> r.uta == `TLB_RST_ACT && r.voa == `TLB_RST_ACT;
  endproperty
  a_act_reset: assert property (p_act_reset) else $error("bad action reset"); // [R7]

  property p_word_rd;
    @(posedge core_clk_in) disable iff (!nrst_in)
      reg_rd_in && !reg_wr_in && reg_cmd_in == `TLB_CMD_OTW
      |=> reg_ack_out && reg_rdata_out == $past(r.otw);
  endproperty
  a_word_rd: assert property (p_word_rd) else $error("word read mismatch"); // [R20]
endmodule : tlb_limit_bank

// ==== tlb_defs.svh ====
// Command codes, reset values, field positions, ranges and timing for the limit bank.
// Assumes inclusion by tlb_limit_bank.sv; tlb_pkg.sv does not include it.
`ifndef TLB_DEFS_SVH
`define TLB_DEFS_SVH
`define TLB_CMD_OTW 8'h51
`define TLB_CMD_UTW 8'h52
`define TLB_CMD_UTF 8'h53
`define TLB_CMD_UTA 8'h54
`define TLB_CMD_VOF 8'h55
`define TLB_CMD_VOA 8'h56
`define TLB_RST_OTW 16'heb70
`define TLB_RST_UTW 16'he4e0
`define TLB_RST_UTF 16'he490
`define TLB_RST_VOF 16'hd3a0
`define TLB_RST_ACT 8'h80
`define TLB_EXP_HI 15
`define TLB_EXP_LO 11
`define TLB_MAN_HI 10
`define TLB_FRAC 16
`define TLB_OT_MIN 0
`define TLB_OT_MAX 175
`define TLB_UT_MIN (-55)
`define TLB_UT_MAX 25
`define TLB_VO_MIN 0
`define TLB_VO_MAX 16
`define TLB_BEH_IGN 2'h0
`define TLB_BEH_DLY 2'h1
`define TLB_BEH_OFF 2'h2
`define TLB_BEH_HLD 2'h3
`define TLB_RTY_NONE 3'h0
`define TLB_RTY_CONT 3'h7
`define TLB_CLK_NS 5
`define TLB_UT_UNIT_US 1000
`define TLB_VO_UNIT_US 1000
`define TLB_CYC(us) (((us) * 1000) / `TLB_CLK_NS)
`endif

// ==== tlb_pkg.sv ====
// Types shared by the limit bank and its fault response engines.
// Assumes nothing beyond a SystemVerilog compiler.
package tlb_pkg;
  typedef enum logic [4:0] {
    st_idle  = 5'h01,
    st_delay = 5'h02,
    st_off   = 5'h04,
    st_wait  = 5'h08,
    st_latch = 5'h10
  } tlb_state_type;

  typedef struct packed {
    logic [1:0] beh;
    logic [2:0] retry;
    logic [2:0] tim;
  } tlb_action_type;

  typedef struct packed {
    tlb_state_type state;
    logic          held;
    logic [31:0]   cnt;
    logic [2:0]    tries;
    logic          en;
  } tlb_resp_reg_type;

  typedef struct packed {
    logic ot_warn;
    logic ut_warn;
    logic ut_fault;
    logic vin_ov;
  } tlb_status_type;

  typedef struct packed {
    logic [15:0]    otw;
    logic [15:0]    utw;
    logic [15:0]    utf;
    tlb_action_type uta;
    logic [15:0]    vof;
    tlb_action_type voa;
    logic           ut_present;
    tlb_status_type sts;
    logic [15:0]    rdata;
    logic           ack;
    logic           nak;
  } tlb_bank_reg_type;
endpackage : tlb_pkg

// ==== tlb_host_model.sv ====
// Host model for the command port: one read or write at a time.
// Assumes the bank acknowledges within four cycles of the taking edge.
`timescale 1ns/1ps
module tlb_host_model (
  input  wire logic        core_clk_in,   // Core clock.
  input  wire logic        reg_ack_in,    // Access done.
  input  wire logic        reg_nak_in,    // Access refused.
  input  wire logic [15:0] reg_rdata_in,  // Read data.
  output logic             reg_wr_out,    // Write strobe.
  output logic             reg_rd_out,    // Read strobe.
  output logic [7:0]       reg_cmd_out,   // Command code.
  output logic [15:0]      reg_wdata_out  // Write data.
);
  initial begin
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_cmd_out = 8'h00;
    reg_wdata_out = 16'h0000;
  end

  // Thresholds arrive already coded as linear words.
  task automatic xfer(input logic wr, input logic [7:0] cmd, input logic [15:0] wd,
                      output logic [15:0] rd, output logic nak, output logic ok);
    int n;
    ok = 1'b0;
    rd = 16'h0000;
    nak = 1'b0;
    @(posedge core_clk_in);
    reg_wr_out <= wr;
    reg_rd_out <= ~wr;
    reg_cmd_out <= cmd;
    reg_wdata_out <= wd;
    @(posedge core_clk_in);
    reg_wr_out <= 1'b0;
    reg_rd_out <= 1'b0;
    // The acknowledge is registered at the taking edge and stands for one cycle only.
    for (n = 0; n < 4 && !ok; n++) begin
      #1;
      if (reg_ack_in === 1'b1) begin
        rd = reg_rdata_in;
        nak = reg_nak_in;
        ok = 1'b1;
      end else begin
        @(posedge core_clk_in);
      end
    end
    // Released lines show the inverse so that a stale value cannot pass.
    reg_cmd_out <= ~cmd;
    reg_wdata_out <= ~wd;
  endtask : xfer
endmodule : tlb_host_model

// ==== testbench.sv ====
// Self-checking bench for the limit bank with a host model on the command port.
// Assumes the bank with short time units of four cycles.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module testbench;
  typedef struct packed {
    logic        wr;
    logic [7:0]  cmd;
    logic [15:0] wd;
    logic [15:0] rd;
    logic        nak;
  } tlb_row_type;
  localparam logic [15:0] t_ok = 16'h0014;
  localparam logic [15:0] t_uw = 16'h07cc;
  localparam logic [15:0] t_uf = 16'h07c4;
  localparam logic [15:0] v_ok = 16'h000c;
  localparam logic [15:0] v_hi = 16'h000f;
  logic core_clk_in = 1'b0;
  logic nrst_in, run_en_in, clear_faults_in, reg_wr_in, reg_rd_in;
  logic [15:0] temp_l11_in, vin_l11_in, reg_wdata_in, reg_rdata_out;
  logic [7:0] reg_cmd_in;
  logic reg_ack_out, reg_nak_out, temp_summary_out, host_alert_out, output_en_out;
  tlb_pkg::tlb_status_type status_out;
  int n_fail = 0;
  int checks = 0;
  int c, r;
  tlb_row_type rows [20] = '{
    '{1'b0, 8'h51, 16'h0000, 16'heb70, 1'b0}, '{1'b0, 8'h52, 16'h0000, 16'he4e0, 1'b0},
    '{1'b0, 8'h53, 16'h0000, 16'he490, 1'b0}, '{1'b0, 8'h54, 16'h0000, 16'h0080, 1'b0},
    '{1'b0, 8'h55, 16'h0000, 16'hd3a0, 1'b0}, '{1'b0, 8'h56, 16'h0000, 16'h0080, 1'b0},
    '{1'b0, 8'h57, 16'h0000, 16'h0000, 1'b1}, '{1'b1, 8'h51, 16'h00b0, 16'h0000, 1'b1},
    '{1'b1, 8'h51, 16'h07ff, 16'h0000, 1'b1}, '{1'b1, 8'h51, 16'h00af, 16'h0000, 1'b0},
    '{1'b0, 8'h51, 16'h0000, 16'h00af, 1'b0}, '{1'b1, 8'h52, 16'h07c8, 16'h0000, 1'b1},
    '{1'b1, 8'h53, 16'h001a, 16'h0000, 1'b1}, '{1'b1, 8'h53, 16'h0019, 16'h0000, 1'b0},
    '{1'b0, 8'h53, 16'h0000, 16'h0019, 1'b0}, '{1'b1, 8'h55, 16'h0011, 16'h0000, 1'b1},
    '{1'b1, 8'h55, 16'h0010, 16'h0000, 1'b0}, '{1'b1, 8'h56, 16'h12c5, 16'h0000, 1'b0},
    '{1'b0, 8'h56, 16'h0000, 16'h00c5, 1'b0}, '{1'b0, 8'h52, 16'h0000, 16'he4e0, 1'b0}};

  always #2.5 core_clk_in = ~core_clk_in;

  tlb_limit_bank #(.UT_UNIT_CYCLES(4), .VO_UNIT_CYCLES(4)) i_dut (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in), .temp_l11_in(temp_l11_in),
    .vin_l11_in(vin_l11_in), .run_en_in(run_en_in), .clear_faults_in(clear_faults_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_cmd_in(reg_cmd_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .reg_ack_out(reg_ack_out),
    .reg_nak_out(reg_nak_out), .status_out(status_out), .temp_summary_out(temp_summary_out),
    .host_alert_out(host_alert_out), .output_en_out(output_en_out));

  tlb_host_model i_host (
    .core_clk_in(core_clk_in), .reg_ack_in(reg_ack_out), .reg_nak_in(reg_nak_out),
    .reg_rdata_in(reg_rdata_out), .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in),
    .reg_cmd_out(reg_cmd_in), .reg_wdata_out(reg_wdata_in));

  task automatic summarize;
    if (n_fail == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  task automatic reg_op(input tlb_row_type w);
    logic [15:0] rd;
    logic nak, ok;
    i_host.xfer(w.wr, w.cmd, w.wd, rd, nak, ok);
    `CHK("ack", 1'b1, ok)
    `CHK("nak", w.nak, nak)
    if (!w.wr) `CHK("rdata", w.rd, rd)
  endtask : reg_op

  task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
    reg_op({1'b1, cmd, d, 16'h0000, 1'b0});
  endtask : wr

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : cyc

  task automatic meas(input logic [15:0] t, input logic [15:0] v);
    @(posedge core_clk_in);
    temp_l11_in <= t;
    vin_l11_in <= v;
    cyc(0);
  endtask : meas

  // Bounded wait for the rail enable to reach a level; c counts cycles taken.
  task automatic wait_en(input logic v, input int lim);
    c = 0;
    while (output_en_out !== v) begin
      cyc(1);
      c++;
      if (c > lim) begin
        n_fail++;
        summarize();
      end
    end
  endtask : wait_en

  task automatic rises(input int n);
    logic p;
    r = 0;
    p = output_en_out;
    repeat (n) begin
      cyc(1);
      if (output_en_out === 1'b1 && p === 1'b0)
        r++;
      p = output_en_out;
    end
  endtask : rises

  // Restart drops the rail enable for one cycle and clears the flags.
  task automatic restart(input logic [7:0] act_cmd, input logic [7:0] act);
    @(posedge core_clk_in);
    run_en_in <= 1'b0;
    clear_faults_in <= 1'b1;
    temp_l11_in <= t_ok;
    vin_l11_in <= v_ok;
    @(posedge core_clk_in);
    run_en_in <= 1'b1;
    clear_faults_in <= 1'b0;
    wr(act_cmd, {8'h00, act});
  endtask : restart

  initial begin
    nrst_in = 1'b0;
    run_en_in = 1'b1;
    clear_faults_in = 1'b0;
    temp_l11_in = t_ok;
    vin_l11_in = v_ok;
    repeat (2) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    foreach (rows[i]) reg_op(rows[i]);
    // A second reset in mid-run must bring every register back.
    @(posedge core_clk_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    for (int i = 0; i < 6; i++) reg_op(rows[i]);
    wr(8'h51, 16'h0064);
    meas(16'h0078, v_ok);
    cyc(3);
    `CHK("ot_warn", 1'b1, status_out.ot_warn)
    `CHK("summary", 1'b1, temp_summary_out)
    `CHK("alert", 1'b1, host_alert_out)
    meas(t_ok, v_ok);
    cyc(4);
    `CHK("sticky", 1'b1, status_out.ot_warn)
    restart(8'h54, 8'hc0);
    `CHK("cleared", 4'h0, status_out)
    meas(t_uw, v_ok);
    cyc(4);
    `CHK("ut_warn", 2'b10, {status_out.ut_warn, status_out.ut_fault})
    `CHK("summary", 1'b1, temp_summary_out)
    meas(t_uf, v_ok);
    wait_en(1'b0, 6);
    cyc(2);
    `CHK("ut_fault", 1'b1, status_out.ut_fault)
    meas(t_uw, v_ok);
    cyc(8);
    `CHK("hyst_en", 1'b0, output_en_out)
    meas(t_ok, v_ok);
    wait_en(1'b1, 6);
    restart(8'h54, 8'h80);
    meas(t_uf, v_ok);
    wait_en(1'b0, 4);
    meas(t_ok, v_ok);
    cyc(20);
    `CHK("latched", 1'b0, output_en_out)
    restart(8'h56, 8'h00);
    `CHK("restarted", 1'b1, output_en_out)
    meas(t_ok, v_hi);
    cyc(6);
    `CHK("vin_ov", 1'b1, status_out.vin_ov)
    `CHK("ignore_en", 1'b1, output_en_out)
    restart(8'h56, 8'h42);
    meas(t_ok, v_hi);
    wait_en(1'b0, 14);
    `CHK("delay_ok", 1'b1, (c >= 7))
    cyc(20);
    `CHK("delay_off", 1'b0, output_en_out)
    restart(8'h56, 8'h91);
    meas(t_ok, v_hi);
    rises(120);
    `CHK("retry_cnt", 2, r)
    restart(8'h56, 8'hbf);
    meas(t_ok, v_hi);
    rises(100);
    `CHK("spacing", 3, r)
    restart(8'h56, 8'hb8);
    meas(t_ok, v_hi);
    rises(100);
    `CHK("continuous", 1'b1, (r > 6))
    summarize();
  end
endmodule : testbench
